// ===== nrc_defines.svh
// constants for the nand rom host controller
`ifndef NRC_DEFINES_SVH
`define NRC_DEFINES_SVH
`define NRC_CMD_READ1    8'h00
`define NRC_CMD_READ2    8'h01
`define NRC_CMD_READ3    8'h50
`define NRC_CMD_RESET    8'hff
`define NRC_CMD_STATUS   8'h70
`define NRC_CMD_ID       8'h90
`define NRC_ID_ADDR      8'h00
`define NRC_CLK_NS       50
`define NRC_TWP_NS       25
`define NRC_TRP_NS       35
`define NRC_TRR_NS       20
`define NRC_TWP_CYC      (((`NRC_TWP_NS) + (`NRC_CLK_NS) - 1) / (`NRC_CLK_NS))
`define NRC_TRP_CYC      (((`NRC_TRP_NS) + (`NRC_CLK_NS) - 1) / (`NRC_CLK_NS))
`define NRC_SETUP_CYC    3'h2
`define NRC_CNT_W        3
`define NRC_ADDR_LO      7:0
`define NRC_ADDR_MID     15:8
`define NRC_ADDR_HI      23:16
`endif

// ===== nrc_host.sv
// host controller that drives a nand style read only memory
//
// Contract
// RQ1 - read codes 00h, 01h, 50h select areas
// RQ2 - also reset ffh, status 70h, id 90h
// RQ3 - host issues only the six codes
// RQ4 - while busy only reset is issued
// RQ5 - mode three data reads all ffh
// RQ6 - id command followed by address 00h
// RQ7 - three address cycles, low byte first
// RQ8 - mode three uses first cycle bits 0-3
// RQ9 - address bit a8 never sent
// RQ10 - address cycles follow command directly
// RQ11 - no read strobe after last until ready
// RQ12 - read strobe only during data output
// RQ13 - power up: chip select high, then reset
// RQ14 - stopped read needs new command and address
// RQ15 - chip select rises soon after last strobe
// RQ16 - command latched on write strobe, cle high
// RQ17 - address latched on write strobe, ale high
// RQ18 - device address counts up per strobe
// RQ19 - status byte bit0 busy, bit6 ready
// RQ20 - reset abandons read, returns ready
// RQ21 - id read gives maker then device code
`timescale 1ns/1ps
`include "nrc_defines.svh"
module nrc_host
  import nrc_pkg::*;
(
  input  wire logic             core_clk,       // 20 mhz clock
  input  wire logic             nrst,           // async reset, active low
  input  wire logic             reqValid,       // user order strobe
  output logic                  reqReady,       // idle, order taken
  input  wire nrc_pkg::nrc_op_t reqOp,          // order kind
  input  wire logic [23:0]      reqAddr,        // address bytes, low first
  input  wire logic [15:0]      reqLen,         // bytes to read, 0 means one
  output logic                  rspValid,       // one-cycle data pulse
  output logic [7:0]            rspData,        // byte read
  output logic                  done,           // one-cycle end pulse
  output nrc_pkg::nrc_pins_t    pins,           // strobes to the device
  output logic [7:0]            ioOut,          // bus output value
  output logic                  ioOe,           // bus output enable
  input  wire logic [7:0]       ioIn,           // bus input
  input  wire logic             readyBusy       // ready high, busy low
);
  import nrc_pkg::*;

  nrc_state_t        state_q;                   // sequencer state
  nrc_op_t           op_q;                      // order in progress
  logic [23:0]       addr_q;                    // address bytes
  logic [15:0]       left_q;                    // bytes still to read
  logic [1:0]        aIdx_q;                    // address cycle index
  logic [1:0]        aLast_q;                   // last address index
  logic [2:0]        cnt_q;                     // phase timer
  logic              powerUp_q;                 // reset not yet issued
  logic [7:0]        ioMeta_q, ioSync_q;        // bus synchroniser
  logic              rbMeta_q, rbSync_q;        // ready/busy synchroniser
  logic              rspValid_q, done_q, reqReady_q, ioOe_q;
  logic [7:0]        rspData_q, ioOut_q;
  nrc_pins_t         pins_q;

  // command byte for an order
  function automatic logic [7:0] opCode(input nrc_op_t op);
    unique case (op)
      OP_READ1:  opCode = `NRC_CMD_READ1;       // see RQ1
      OP_READ2:  opCode = `NRC_CMD_READ2;       // see RQ1
      OP_READ3:  opCode = `NRC_CMD_READ3;       // see RQ1
      OP_RESET:  opCode = `NRC_CMD_RESET;       // see RQ2
      OP_STATUS: opCode = `NRC_CMD_STATUS;      // see RQ2
      default:   opCode = `NRC_CMD_ID;          // see RQ2
    endcase
  endfunction : opCode

  // address byte for a cycle index
  function automatic logic [7:0] addrByte(input logic [1:0] i, input logic [23:0] a, input nrc_op_t op);
    if (op == OP_ID)
      addrByte = `NRC_ID_ADDR;                  // see RQ6
    else if (i == 2'h0)
      addrByte = (op == OP_READ3) ? {4'h0, a[3:0]} : a[`NRC_ADDR_LO]; // see RQ8
    else if (i == 2'h1)
      addrByte = a[`NRC_ADDR_MID];              // see RQ7 RQ9
    else
      addrByte = a[`NRC_ADDR_HI];               // see RQ7
  endfunction : addrByte

  // two flip-flops on device inputs
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      ioMeta_q <= 8'h00;
      ioSync_q <= 8'h00;
      rbMeta_q <= 1'b0;
      rbSync_q <= 1'b0;
    end
    else
    begin
      ioMeta_q <= ioIn;
      ioSync_q <= ioMeta_q;
      rbMeta_q <= readyBusy;
      rbSync_q <= rbMeta_q;
    end

  // main sequencer
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      state_q    <= ST_IDLE;
      op_q       <= OP_RESET;
      addr_q     <= 24'h000000;
      left_q     <= 16'h0000;
      aIdx_q     <= 2'h0;
      aLast_q    <= 2'h0;
      cnt_q      <= 3'h0;
      powerUp_q  <= 1'b1;
      pins_q     <= '{cmdLatch: 1'b0, addrLatch: 1'b0, chipSel_n: 1'b1,
                      writeStrobe_n: 1'b1, read_strobe_n: 1'b1}; // see RQ13
      ioOut_q    <= 8'h00;
      ioOe_q     <= 1'b0;
      rspValid_q <= 1'b0;
      rspData_q  <= 8'h00;
      done_q     <= 1'b0;
      reqReady_q <= 1'b0;
    end
    else
    begin
      rspValid_q <= 1'b0;
      done_q     <= 1'b0;
      unique case (state_q)
        // wait for an order; before the first reset only reset runs
        ST_IDLE:
        begin
          pins_q.chipSel_n <= 1'b1;
          reqReady_q <= !powerUp_q || (reqValid && reqOp == OP_RESET);
          if (powerUp_q)
          begin
            // power-up: issue reset on our own while chip select idle
            op_q    <= OP_RESET;                // see RQ13
            state_q <= ST_CMD;
            cnt_q   <= 3'h0;
          end
          else if (reqValid && (rbSync_q || reqOp == OP_RESET)) // see RQ4
          begin
            op_q    <= reqOp;                   // see RQ3
            addr_q  <= reqAddr;
            left_q  <= reqLen;
            state_q <= ST_CMD;
            cnt_q   <= 3'h0;
            reqReady_q <= 1'b0;
          end
        end
        // command cycle, cle high, write strobe pulse
        ST_CMD:
        begin
          pins_q.chipSel_n <= 1'b0;
          pins_q.cmdLatch  <= 1'b1;             // see RQ16
          ioOut_q <= opCode(op_q);
          ioOe_q  <= 1'b1;
          cnt_q   <= cnt_q + 3'h1;
          // strobe low first, so it rises while the latch is still high
          pins_q.writeStrobe_n <= !(cnt_q < 3'(`NRC_TWP_CYC));
          if (cnt_q == `NRC_SETUP_CYC)
          begin
            pins_q.cmdLatch <= 1'b0;
            cnt_q  <= 3'h0;
            aIdx_q <= 2'h0;
            aLast_q <= (op_q == OP_ID) ? 2'h0 : 2'h2;
            powerUp_q <= 1'b0;
            // address follows the command with no gap
            state_q <= (op_q == OP_RESET || op_q == OP_STATUS) ? ST_WREC : ST_ADDR; // see RQ10
          end
        end
        // address cycles, ale high
        ST_ADDR:
        begin
          pins_q.addrLatch <= 1'b1;             // see RQ17
          ioOut_q <= addrByte(aIdx_q, addr_q, op_q);
          cnt_q   <= cnt_q + 3'h1;
          // strobe rises a cycle before the latch may drop
          pins_q.writeStrobe_n <= !(cnt_q < 3'(`NRC_TWP_CYC));
          if (cnt_q == `NRC_SETUP_CYC)
          begin
            cnt_q <= 3'h0;
            if (aIdx_q == aLast_q)
            begin
              pins_q.addrLatch <= 1'b0;
              state_q <= ST_WREC;
            end
            else
              aIdx_q <= aIdx_q + 2'h1;
          end
        end
        // release bus, allow device to drop ready
        ST_WREC:
        begin
          ioOe_q <= 1'b0;
          cnt_q  <= cnt_q + 3'h1;
          if (cnt_q == `NRC_SETUP_CYC)
          begin
            cnt_q   <= 3'h0;
            state_q <= ST_WAITRB;
          end
        end
        // wait ready before reading or ending
        ST_WAITRB:
          if (rbSync_q)                         // see RQ11 RQ20
          begin
            if (op_q == OP_RESET)
              state_q <= ST_STOP;
            else
              state_q <= ST_RLOW;               // see RQ12
          end
        // read strobe low, sample byte at end
        ST_RLOW:
        begin
          pins_q.read_strobe_n <= 1'b0;         // see RQ12
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'(`NRC_TRP_CYC + 2))    // two sync stages behind the pin
          begin
            rspData_q  <= ioSync_q;             // see RQ5 RQ19 RQ21
            rspValid_q <= 1'b1;
            pins_q.read_strobe_n <= 1'b1;       // see RQ18
            cnt_q   <= 3'h0;
            state_q <= ST_RHIGH;
          end
        end
        // read strobe high; next byte, page busy wait, or stop
        ST_RHIGH:
        begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `NRC_SETUP_CYC)
          begin
            cnt_q <= 3'h0;
            if (left_q == 16'h0000 || left_q == 16'h0001)
              state_q <= ST_STOP;
            else
            begin
              left_q  <= left_q - 16'h0001;
              state_q <= ST_WAITRB;             // see RQ11
            end
          end
        end
        // chip select high ends the read; reread needs new order
        ST_STOP:
        begin
          pins_q.chipSel_n <= 1'b1;             // see RQ14 RQ15
          done_q  <= 1'b1;
          reqReady_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end

  assign pins     = pins_q;
  assign ioOut    = ioOut_q;
  assign ioOe     = ioOe_q;
  assign rspValid = rspValid_q;
  assign rspData  = rspData_q;
  assign done     = done_q;
  assign reqReady = reqReady_q;

  a_strobe_excl: assert property (@(posedge core_clk) disable iff (!nrst)
    !(pins_q.cmdLatch && pins_q.addrLatch)) else $error("both latches high"); // see RQ16
  a_read_idle: assert property (@(posedge core_clk) disable iff (!nrst)
    !pins_q.read_strobe_n |-> !pins_q.cmdLatch && !pins_q.addrLatch && !ioOe_q) else $error("read strobe outside output"); // see RQ12
  a_latch_hold: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ16 RQ17
    $rose(pins_q.writeStrobe_n) |-> (pins_q.cmdLatch || pins_q.addrLatch))
    else $error("latch dropped with write strobe");
  a_cmd_when_ready: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == ST_IDLE && !powerUp_q && reqValid && !rbSync_q && reqOp != OP_RESET) |=> state_q == ST_IDLE)
    else $error("command issued while busy"); // see RQ4
  a_read_after_ready: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(pins_q.read_strobe_n) |-> $past(rbSync_q, 2)) else $error("read strobe before ready"); // see RQ11
  a_id_addr: assert property (@(posedge core_clk) disable iff (!nrst)
    (pins_q.addrLatch && op_q == OP_ID && !pins_q.writeStrobe_n) |-> ioOut_q == `NRC_ID_ADDR) else $error("id address not zero"); // see RQ6
  a_mode3_addr: assert property (@(posedge core_clk) disable iff (!nrst)
    (pins_q.addrLatch && op_q == OP_READ3 && aIdx_q == 2'h0 && !pins_q.writeStrobe_n) |-> ioOut_q[7:4] == 4'h0)
    else $error("mode three high bits driven"); // see RQ8
  a_cmd_code: assert property (@(posedge core_clk) disable iff (!nrst)
    (pins_q.cmdLatch && !pins_q.writeStrobe_n) |-> ioOut_q inside {8'h00, 8'h01, 8'h50, 8'hff, 8'h70, 8'h90})
    else $error("undefined command code"); // see RQ3
  a_stop_cs: assert property (@(posedge core_clk) disable iff (!nrst)
    done_q |-> pins_q.chipSel_n) else $error("chip select low after stop"); // see RQ14
  c_read1: cover property (@(posedge core_clk) disable iff (!nrst) done_q && op_q == OP_READ1);
  c_status: cover property (@(posedge core_clk) disable iff (!nrst) rspValid_q && op_q == OP_STATUS);
  c_id: cover property (@(posedge core_clk) disable iff (!nrst) rspValid_q && op_q == OP_ID);
endmodule : nrc_host

// ===== nrc_host_tb_top.sv
// self-checking bench for the nand rom host controller
`timescale 1ns/1ps
module nrc_host_tb_top;
  import nrc_pkg::*;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
  localparam logic [7:0] DEVC  = 8'hc3; // arbitrary value
  logic        core_clk = 1'b0;  // 20 mhz clock
  logic        nrst     = 1'b0;  // reset, active low
  logic        reqValid = 1'b0;  // order strobe
  nrc_op_t     reqOp    = OP_RESET; // order kind
  logic [23:0] reqAddr  = 24'h0; // address bytes
  logic [15:0] reqLen   = 16'h0; // byte count
  logic        reqReady, rspValid, done, ioOe, readyBusy;
  logic [7:0]  rspData, ioOut, ioIn;
  nrc_pins_t   pins;
  int          violations, fails = 0, tests_run = 0;
  logic [7:0]  got[$];           // bytes returned by one order
  nrc_host nrc_host_inst (.core_clk(core_clk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady),
    .reqOp(reqOp), .reqAddr(reqAddr), .reqLen(reqLen), .rspValid(rspValid), .rspData(rspData), .done(done),
    .pins(pins), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .readyBusy(readyBusy));
  nrc_rom_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVC)) nrc_rom_model_inst (.pins(pins), .ioOut(ioOut),
    .ioOe(ioOe), .ioIn(ioIn), .readyBusy(readyBusy), .violations(violations));
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end
  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // compare one byte
  task automatic chkByte(input string name, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chkByte
  // compare one count
  task automatic chkCount(input string name, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %0d seen %0d", name, exp, seen);
    end
  endtask : chkCount
  // gather bytes until the end pulse, bounded
  task automatic collect();
    int n;
    n = 0;
    got.delete();
    while (done !== 1'b1 && n < 4000)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (rspValid === 1'b1) got.push_back(rspData);
    end
    if (n >= 4000)
    begin
      fails++;
      results();
    end
  endtask : collect
  // hand one order over and wait for its end
  task automatic runOrder(input nrc_op_t op, input logic [23:0] a, input logic [15:0] len);
    int n;
    n = 0;
    reqOp = op;
    reqAddr = a;
    reqLen = len;
    reqValid = 1'b1;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end while (reqReady !== 1'b0 && n < 400);
    if (reqReady !== 1'b0)
    begin
      fails++;
      results();
    end
    reqValid = 1'b0;
    collect();
  endtask : runOrder
  // array read, expected bytes from the address map
  task automatic readCheck(input nrc_op_t op, input logic [23:0] a, input logic [15:0] len);
    logic [24:0] sa;
    logic [7:0]  e;
    sa = {a[23:16], a[15:8], op == OP_READ2, a[7:0]};
    runOrder(op, a, len);
    chkCount("read bytes", (len == 16'h0) ? 16'h1 : len, 16'(got.size()));
    for (int i = 0; i < got.size(); i++)
    begin
      e = sa[7:0] ^ sa[16:9] ^ {sa[8], sa[24:18]};
      if (op == OP_READ3) e = 8'hff;
      chkByte("read data", e, got[i]);
      sa = sa + 25'h1;
    end
  endtask : readCheck
  // main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    #1 nrst = 1'b1;
    collect();
    chkCount("power up bytes", 16'h0, 16'(got.size()));
    readCheck(OP_READ1, 24'h5aa5ff, 16'h3);
    readCheck(OP_READ2, 24'h0102fe, 16'h2);
    readCheck(OP_READ3, 24'h3412f7, 16'h2);
    runOrder(OP_STATUS, 24'h0, 16'h0);
    chkCount("status bytes", 16'h1, 16'(got.size()));
    chkByte("status", 8'h40, got[0]);
    runOrder(OP_ID, 24'h0, 16'h2);
    chkCount("id bytes", 16'h2, 16'(got.size()));
    chkByte("maker code", MAKER, got[0]);
    chkByte("device code", DEVC, got[1]);
    runOrder(OP_RESET, 24'h0, 16'h0);
    chkCount("reset bytes", 16'h0, 16'(got.size()));
    readCheck(OP_READ1, 24'h000010, 16'h0);
    chkCount("host faults", 16'h0, 16'(violations));
    results();
  end
endmodule : nrc_host_tb_top

// ===== nrc_pkg.sv
// types for the nand rom host controller
package nrc_pkg;
  // pins toward the device
  typedef struct packed {
    logic       cmdLatch;
    logic       addrLatch;
    logic       chipSel_n;
    logic       writeStrobe_n;
    logic       read_strobe_n;
  } nrc_pins_t;
  // user order
  typedef enum logic [2:0] {
    OP_READ1  = 3'b000,
    OP_READ2  = 3'b001,
    OP_READ3  = 3'b010,
    OP_RESET  = 3'b011,
    OP_STATUS = 3'b100,
    OP_ID     = 3'b101
  } nrc_op_t;
  // controller states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_CMD    = 4'b0001,
    ST_ADDR   = 4'b0010,
    ST_WREC   = 4'b0011,
    ST_WAITRB = 4'b0100,
    ST_RLOW   = 4'b0101,
    ST_RHIGH  = 4'b0110,
    ST_STOP   = 4'b0111
  } nrc_state_t;
endpackage : nrc_pkg

// ===== nrc_rom_model.sv
// behavioural model of the nand style read only memory
`timescale 1ns/1ps
`include "nrc_defines.svh"
module nrc_rom_model
  import nrc_pkg::*;
#(
  parameter int         BUSY_NS    = 600,   // array fetch time, shortened
  parameter int         RST_NS     = 300,   // reset recovery, shortened
  parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] DEV_CODE   = 8'hc3  // arbitrary value
)(
  input  wire nrc_pkg::nrc_pins_t pins,      // strobes from the host
  input  wire logic [7:0]         ioOut,     // host bus value
  input  wire logic               ioOe,      // host drives the bus
  output logic [7:0]              ioIn,      // resolved bus level
  output logic                    readyBusy, // pulled up when ready
  output int                      violations // host faults seen
);
  logic [7:0]  cmd       = `NRC_CMD_RESET; // mode code, reset means none
  logic [1:0]  addrCnt   = 2'h0;          // address cycles taken
  logic [24:0] addr      = 25'h0;         // internal read address
  logic        busy      = 1'b0;          // internal busy flag
  logic        outPhase  = 1'b0;          // data output phase open
  logic        resetSeen = 1'b0;          // reset given since power up
  logic        idIdx     = 1'b0;          // id byte index
  logic [7:0]  curByte;                   // byte on offer
  initial violations = 0;
  // released bus shows the inverse, never a stale value
  assign ioIn = ioOe ? ioOut : ((!pins.chipSel_n && !pins.read_strobe_n) ? curByte : ~curByte);
  assign readyBusy = !busy;
  // byte chosen by the selected mode
  always_comb
  begin
    if (cmd == `NRC_CMD_STATUS) curByte = {1'b0, !busy, 5'h00, busy};
    else if (cmd == `NRC_CMD_ID) curByte = idIdx ? DEV_CODE : MAKER_CODE;
    else if (cmd == `NRC_CMD_READ3) curByte = 8'hff;
    else curByte = addr[7:0] ^ addr[16:9] ^ {addr[8], addr[24:18]};
  end
  // command and address capture on write strobe rise
  always @(posedge pins.writeStrobe_n)
  begin
    if (!pins.chipSel_n && pins.cmdLatch)
    begin
      if (busy && ioIn != `NRC_CMD_RESET) violations++;
      if (!(ioIn inside {8'h00, 8'h01, 8'h50, 8'hff, 8'h70, 8'h90})) violations++;
      if (!resetSeen && ioIn != `NRC_CMD_RESET) violations++;
      resetSeen = resetSeen | (ioIn == `NRC_CMD_RESET);
      cmd = ioIn;
      addrCnt = 2'h0;
      idIdx = 1'b0;
      outPhase = (ioIn == `NRC_CMD_STATUS);
      if (ioIn == `NRC_CMD_RESET)
      begin
        busy = 1'b1;
        busy <= #(RST_NS) 1'b0;
      end
    end
    else if (!pins.chipSel_n && pins.addrLatch)
    begin
      if (cmd inside {`NRC_CMD_RESET, `NRC_CMD_STATUS} || outPhase) violations++;
      if (cmd == `NRC_CMD_ID && ioIn != `NRC_ID_ADDR) violations++;
      case (addrCnt)
        2'h0: addr[8:0] = {cmd == `NRC_CMD_READ2, (cmd == `NRC_CMD_READ3) ? {4'h0, ioIn[3:0]} : ioIn};
        2'h1: addr[16:9] = ioIn;
        default: addr[24:17] = ioIn;
      endcase
      addrCnt = addrCnt + 2'h1;
      outPhase = (cmd == `NRC_CMD_ID) || (addrCnt == 2'h3);
      if (addrCnt == 2'h3)
      begin
        busy = 1'b1;
        busy <= #(BUSY_NS) 1'b0;
      end
    end
  end
  // chip select high abandons the read
  always @(posedge pins.chipSel_n) outPhase = 1'b0;
  // read strobe only in an output phase while ready
  always @(negedge pins.read_strobe_n) if (!outPhase || busy) violations++;
  // counter steps on each strobe rise in an output phase
  always @(posedge pins.read_strobe_n)
  begin
    if (outPhase)
    begin
      addr = addr + 25'h1;
      idIdx = 1'b1;
    end
  end
endmodule : nrc_rom_model
